// file: bench/ecm_link_asserts.sv
// Concurrent checks on the link between the bus master and the ECC memory.
// Assumes one clock domain and the active-low asynchronous reset rst_b.
`timescale 1ns/100ps
module ecm_link_asserts (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req,
  input wire logic write,
  input wire logic [ecm_pkg::ECM_AW-1:0] addr,
  input wire logic ready,
  input wire logic rvalid,
  input wire logic [63:0] rdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic ecc_irq
);
  logic take;
  logic [2:0] gctrl_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // An access is taken on an edge with request and ready both high
  assign take = req && ready;

  // Shadow of the global control word; cache ECC bit moves only while cache is off
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gctrl_reg <= {ecm_pkg::ECM_CECC_RST, 2'h0};
    end else if (cfg_wr && cfg_addr == ecm_pkg::ECM_CFG_GCTRL) begin
      gctrl_reg[1:0] <= cfg_wdata[1:0];
      if (!gctrl_reg[1]) begin
        gctrl_reg[2] <= cfg_wdata[2];
      end
    end
  end

  a_busy_after_take: assert property (take |=> !ready)
    else $error("ready stayed high after a taken access");
  a_answer_in_time: assert property (take |-> ##[1:5] rvalid)
    else $error("access not answered within five cycles");
  a_close_ram_direct: assert property (take && addr[4] |=> rvalid)
    else $error("close RAM access went through the cache");
  a_close_ram_width: assert property (take && !write && addr[4] |=> rdata[63:32] == 32'h0)
    else $error("close RAM read returned upper bits");
  a_write_answer: assert property (take && write |=> rvalid && rdata == 64'h0)
    else $error("write not answered with empty data");
  a_ready_returns: assert property (rvalid |=> ready)
    else $error("ready did not return after the answer");
  a_cfg_quiet: assert property (!cfg_rd |=> cfg_rdata == 32'h0)
    else $error("config read data without a read");
  a_gctrl_value: assert property (cfg_rd && cfg_addr == ecm_pkg::ECM_CFG_GCTRL |=> cfg_rdata[2:0] == gctrl_reg)
    else $error("global control word read wrong");
  a_irq_gated: assert property (!gctrl_reg[0] && !$past(gctrl_reg[0]) |-> !ecc_irq)
    else $error("interrupt high while globally disabled");
endmodule // ecm_link_asserts

// file: bench/tb_sram_cache_secded_monitor.sv
// Testbench: software port drives the controller, which faces the ECC memory.
// Assumes the controller register map of the hand-over and a 125 MHz clock.
`timescale 1ns/100ps
module tb_sram_cache_secded_monitor;
  localparam logic [3:0] GC = ecm_pkg::ECM_CFG_GCTRL;
  localparam logic [3:0] INJ = ecm_pkg::ECM_CFG_INJECT;
  localparam logic [3:0] CTRL0 = 4'(ecm_pkg::ECM_CFG_MON_BASE + ecm_pkg::ECM_MON_CTRL);
  localparam logic [3:0] STAT0 = 4'(ecm_pkg::ECM_CFG_MON_BASE + ecm_pkg::ECM_MON_STAT);
  localparam logic [3:0] FADDR0 = 4'(ecm_pkg::ECM_CFG_MON_BASE + ecm_pkg::ECM_MON_FADDR);
  localparam logic [3:0] FDLO0 = 4'(ecm_pkg::ECM_CFG_MON_BASE + ecm_pkg::ECM_MON_FDLO);
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic ecc_irq;
  logic [63:0] mem_m [32] = '{default: 64'h0};
  logic [63:0] q;
  logic [31:0] r;
  int fail_count = 0;
  int compares = 0;

  ecm_link_if lnk ();
  ecm_bus_host ecm_bus_host_inst (.clock(clock), .rst_b(rst_b), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .lnk(lnk.host));
  ecm_mem_dev ecm_mem_dev_inst (.clock(clock), .rst_b(rst_b), .lnk(lnk.dev), .ecc_irq(ecc_irq));
  ecm_link_asserts ecm_link_asserts_inst (.clock(clock), .rst_b(rst_b), .req(lnk.req),
    .write(lnk.write), .addr(lnk.addr), .ready(lnk.ready), .rvalid(lnk.rvalid),
    .rdata(lnk.rdata), .cfg_wr(lnk.cfg_wr), .cfg_rd(lnk.cfg_rd), .cfg_addr(lnk.cfg_addr),
    .cfg_wdata(lnk.cfg_wdata), .cfg_rdata(lnk.cfg_rdata), .ecc_irq(ecc_irq));

  // 8 ns system clock
  always #4 clock = ~clock;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One software cycle; read data lands in r
  task automatic sw(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= wr;
    sw_rd <= !wr;
    @(posedge clock);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    #1 r = sw_rdata;
  endtask

  // One memory access through the controller, with the reference model updated
  task automatic op(input logic wr, input logic [4:0] a, input logic [7:0] be,
                    input logic [63:0] d);
    int n;
    n = 0;
    sw(1'b1, ecm_pkg::ECM_SW_ADDR, {27'h0, a});
    sw(1'b1, ecm_pkg::ECM_SW_WDLO, d[31:0]);
    sw(1'b1, ecm_pkg::ECM_SW_WDHI, d[63:32]);
    sw(1'b1, ecm_pkg::ECM_SW_CMD, {16'h0, be, 6'h0, !wr, wr});
    do begin
      sw(1'b0, ecm_pkg::ECM_SW_STATUS, 32'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 20);
    if (n == 20) begin
      fail_count++;
    end
    sw(1'b0, ecm_pkg::ECM_SW_RDLO, 32'h0);
    q[31:0] = r;
    sw(1'b0, ecm_pkg::ECM_SW_RDHI, 32'h0);
    q[63:32] = r;
    for (int b = 0; b < 8; b++) begin
      if (wr && be[b] && !(a[4] && b > 3)) begin
        mem_m[a][8*b +: 8] = d[8*b +: 8];
      end
    end
  endtask

  task automatic cw(input logic [3:0] a, input logic [31:0] d);
    sw(1'b1, ecm_pkg::ECM_SW_CADDR, {28'h0, a});
    sw(1'b1, ecm_pkg::ECM_SW_CDATA, d);
    // Let the strobe reach the memory so flags and interrupt have settled
    @(posedge clock);
    #1;
  endtask

  task automatic cr(input logic [3:0] a);
    sw(1'b1, ecm_pkg::ECM_SW_CADDR, {28'h0, a});
    sw(1'b1, ecm_pkg::ECM_SW_CREAD, 32'h0);
    repeat (3) @(posedge clock);
    sw(1'b0, ecm_pkg::ECM_SW_CDATA, 32'h0);
  endtask

  task automatic complete_run();
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    r = $urandom(42);
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    cr(GC);
    check(r[2:0], 3'h4);
    // Initialise every word, then read all back uncached
    for (int i = 0; i < 32; i++) begin
      op(1'b1, 5'(i), 8'hff, {$urandom, $urandom});
    end
    for (int i = 0; i < 32; i++) begin
      op(1'b0, 5'(i), 8'hff, 64'h0);
      check(q, mem_m[i]);
    end
    // Bring-up order: clear flags, latch and enables, then global interrupt
    cw(STAT0, 32'h3);
    cw(CTRL0, 32'h7);
    cw(GC, 32'h7);
    op(1'b0, 5'h1, 8'hff, 64'h0);
    check(q, mem_m[1]);
    op(1'b0, 5'h2, 8'hff, 64'h0);
    check(q, mem_m[2]);
    cw(GC, 32'h3);
    cr(GC);
    check(r[2:0], 3'h7);
    // Broken cache lines: one bit and two bits, always silent
    for (int k = 1; k < 4; k++) begin
      cw(GC, 32'h5);
      cw(GC, 32'h7);
      cw(INJ, 32'(k << 2));
      op(1'b0, 5'h0, 8'hff, 64'h0);
      check(q, mem_m[0]);
      // Second read hits the broken line: corrected, or refilled on a double error
      op(1'b0, 5'h0, 8'hff, 64'h0);
      check(q, mem_m[0]);
      cr(STAT0);
      check(r, 32'h0);
      check(ecc_irq, 1'b0);
    end
    cw(GC, 32'h5);
    cw(GC, 32'h1);
    cr(GC);
    check(r[2:0], 3'h1);
    cw(GC, 32'h5);
    // Single bit in RAM: corrected twice, never repaired
    cw(INJ, 32'h1);
    op(1'b1, 5'h5, 8'hff, {$urandom, $urandom});
    for (int k = 0; k < 2; k++) begin
      op(1'b0, 5'h5, 8'hff, 64'h0);
      check(q, mem_m[5]);
      cr(STAT0);
      check(r, 32'h1);
      check(ecc_irq, 1'b1);
      cw(STAT0, 32'h1);
    end
    check(ecc_irq, 1'b0);
    cr(FADDR0);
    check(r[4:0], 5'h5);
    cr(FDLO0);
    check(r, mem_m[5][31:0]);
    // Software writes the corrected word back; later reads are clean
    op(1'b1, 5'h5, 8'hff, mem_m[5]);
    op(1'b0, 5'h5, 8'hff, 64'h0);
    check(q, mem_m[5]);
    cr(STAT0);
    check(r, 32'h0);
    // Break the word again for the partial write
    cw(INJ, 32'h1);
    op(1'b1, 5'h5, 8'hff, mem_m[5]);
    // Partial write reads and checks the still broken word
    op(1'b1, 5'h5, 8'h01, {$urandom, $urandom});
    cr(STAT0);
    check(r, 32'h1);
    cw(STAT0, 32'h1);
    op(1'b0, 5'h5, 8'hff, 64'h0);
    check(q, mem_m[5]);
    // Double bit with its interrupt masked, then unmasked, then globally off
    cw(CTRL0, 32'h3);
    cw(INJ, 32'h3);
    op(1'b1, 5'h6, 8'hff, {$urandom, $urandom});
    op(1'b0, 5'h6, 8'hff, 64'h0);
    cr(STAT0);
    check(r, 32'h2);
    check(ecc_irq, 1'b0);
    cw(CTRL0, 32'h5);
    check(ecc_irq, 1'b1);
    cw(GC, 32'h4);
    check(ecc_irq, 1'b0);
    cw(GC, 32'h5);
    check(ecc_irq, 1'b1);
    // Uncorrectable stack word: software answers with a system reset
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    check(ecc_irq, 1'b0);
    cr(STAT0);
    check(r, 32'h0);
    cr(GC);
    check(r[2:0], 3'h4);
    complete_run();
  end
endmodule // tb_sram_cache_secded_monitor

// file: hdl/ecm_bus_host.sv
// Bus master controller: software orders accesses and configuration through registers.
// Assumes the memory subsystem answers cfg reads one cycle after the strobe.
`timescale 1ns/100ps
module ecm_bus_host (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  ecm_link_if.host lnk
);

  localparam int AW = ecm_pkg::ECM_AW;

  typedef enum logic [1:0] {ECM_H_IDLE, ECM_H_REQ, ECM_H_WAIT} ecm_hst_t;

  typedef struct packed {
    ecm_hst_t st;
    logic req;
    logic write;
    logic instr;
    logic [AW-1:0] addr;
    logic [7:0] be;
    logic [63:0] wdata;
    logic [63:0] rd;
    logic cwr;
    logic crd;
    logic [3:0] caddr;
    logic [31:0] cwdata;
    logic [31:0] cdata;
    logic [1:0] cpend;
    logic [31:0] swr;
  } ecm_host_state_t;

  ecm_host_state_t h_reg;
  ecm_host_state_t h_next;

  // Software decode, access sequencing and cfg pipeline
  always_comb begin
    h_next = h_reg;
    h_next.cwr = 1'b0;
    h_next.crd = 1'b0;
    h_next.cpend = {h_reg.cpend[0], 1'b0};
    h_next.swr = 32'h0000_0000;
    if (h_reg.cpend[1]) h_next.cdata = lnk.cfg_rdata;
    if (sw_wr) begin
      case (sw_addr)
        ecm_pkg::ECM_SW_ADDR: h_next.addr = sw_wdata[AW-1:0];
        ecm_pkg::ECM_SW_WDLO: h_next.wdata[31:0] = sw_wdata;
        ecm_pkg::ECM_SW_WDHI: h_next.wdata[63:32] = sw_wdata;
        ecm_pkg::ECM_SW_CMD: begin
          // Reads serve scrubbing, writes serve corrected writeback; busy drops it
          if (h_reg.st == ECM_H_IDLE) begin
            h_next.write = sw_wdata[ecm_pkg::ECM_CMD_WR];
            h_next.instr = sw_wdata[ecm_pkg::ECM_CMD_INSTR];
            h_next.be = sw_wdata[ecm_pkg::ECM_CMD_BE_LSB +: 8];
            h_next.req = 1'b1;
            h_next.st = ECM_H_REQ;
          end
        end
        ecm_pkg::ECM_SW_CADDR: h_next.caddr = sw_wdata[3:0];
        ecm_pkg::ECM_SW_CDATA: begin
          h_next.cwdata = sw_wdata;
          h_next.cwr = 1'b1;
        end
        ecm_pkg::ECM_SW_CREAD: begin
          h_next.crd = 1'b1;
          h_next.cpend[0] = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (sw_rd) begin
      case (sw_addr)
        ecm_pkg::ECM_SW_ADDR: h_next.swr = 32'(h_reg.addr);
        ecm_pkg::ECM_SW_WDLO: h_next.swr = h_reg.wdata[31:0];
        ecm_pkg::ECM_SW_WDHI: h_next.swr = h_reg.wdata[63:32];
        ecm_pkg::ECM_SW_RDLO: h_next.swr = h_reg.rd[31:0];
        ecm_pkg::ECM_SW_RDHI: h_next.swr = h_reg.rd[63:32];
        ecm_pkg::ECM_SW_STATUS: h_next.swr = {30'h0, |h_reg.cpend, h_reg.st != ECM_H_IDLE};
        ecm_pkg::ECM_SW_CADDR: h_next.swr = {28'h0, h_reg.caddr};
        ecm_pkg::ECM_SW_CDATA: h_next.swr = h_reg.cdata;
        default: h_next.swr = 32'h0000_0000;
      endcase
    end
    case (h_reg.st)
      ECM_H_IDLE: begin
      end
      ECM_H_REQ: begin
        if (lnk.ready) begin
          h_next.req = 1'b0;
          h_next.st = ECM_H_WAIT;
        end
      end
      ECM_H_WAIT: begin
        if (lnk.rvalid) begin
          h_next.rd = lnk.rdata;
          h_next.st = ECM_H_IDLE;
        end
      end
      default: h_next.st = ECM_H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      h_reg <= '0;
    end else begin
      h_reg <= h_next;
    end
  end

  // Outputs straight from the state register
  assign lnk.req = h_reg.req;
  assign lnk.write = h_reg.write;
  assign lnk.instr = h_reg.instr;
  assign lnk.addr = h_reg.addr;
  assign lnk.be = h_reg.be;
  assign lnk.wdata = h_reg.wdata;
  assign lnk.cfg_wr = h_reg.cwr;
  assign lnk.cfg_rd = h_reg.crd;
  assign lnk.cfg_addr = h_reg.caddr;
  assign lnk.cfg_wdata = h_reg.cwdata;
  assign sw_rdata = h_reg.swr;

endmodule // ecm_bus_host

// file: hdl/ecm_link_if.sv
// Link between the bus master controller and the ECC memory subsystem.
// Access channel with ready/valid, plus a configuration port answered next cycle.
`timescale 1ns/100ps
interface ecm_link_if;
  logic req;
  logic write;
  logic instr;
  logic [ecm_pkg::ECM_AW-1:0] addr;
  logic [7:0] be;
  logic [63:0] wdata;
  logic ready;
  logic rvalid;
  logic [63:0] rdata;
  logic cfg_wr;
  logic cfg_rd;
  logic [3:0] cfg_addr;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;

  modport dev (
    input req, write, instr, addr, be, wdata, cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
    output ready, rvalid, rdata, cfg_rdata
  );
  modport host (
    output req, write, instr, addr, be, wdata, cfg_wr, cfg_rd, cfg_addr, cfg_wdata,
    input ready, rvalid, rdata, cfg_rdata
  );
endinterface

// file: hdl/ecm_mem_dev.sv
// ECC memory subsystem: SRAM words with two RAM ECC monitors and a one-line cache.
// Assumes the master holds req until ready and keeps cfg strobes one cycle long.
//
// Behaviour
// - One check code covers whole 256-bit line
// - Cache ECC on after reset, software can disable
// - Software disables cache before changing ECC setting
// - Instruction line single error corrected silently
// - Instruction line double error: invalidate, refetch
// - Data line double error reloads from memory
// - Cache ECC has no flags or interrupt
// - Only main bus port accesses use cache
// - Check every read and partial write
// - Correct returned data only, no writeback
// - Latch failing data and address when enabled
// - Software init order: memory, flags, latch, interrupts
// - Each monitor has own interrupt enables
// - Software writes corrected data back after correction
// - Stack double error demands system reset
// - Cacheable miss fills whole line through check
// - Software or DMA scrubs used RAM periodically
// - Global block gathers monitors, one maskable interrupt
// - Main SRAM words 64 bits, others 32
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
module ecm_mem_dev #(
  parameter int DW0 = 64,
  parameter int DW1 = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  ecm_link_if.dev lnk,
  output logic ecc_irq
);

  localparam int AW = ecm_pkg::ECM_AW;
  localparam int DEPTH = 1 << AW;

  typedef enum logic [0:0] {ECM_IDLE, ECM_FILL} ecm_dst_t;

  typedef struct packed {
    ecm_dst_t st;
    logic rdy;
    logic rvalid;
    logic [63:0] rdata;
    logic [31:0] cfg_rdata;
    logic irq;
    logic gie;
    logic cen;
    logic cecc;
    logic [3:0] inj;
    logic [1:0][2:0] mctl;
    logic [1:0][1:0] stat;
    logic [1:0][AW-1:0] faddr;
    logic [1:0][63:0] fdata;
    logic [255:0] line;
    logic [9:0] lchk;
    logic [AW-4:0] ltag;
    logic lval;
    logic [1:0] beat;
    logic [1:0] rword;
    logic [DEPTH-1:0][73:0] mem;
  } ecm_dev_state_t;

  ecm_dev_state_t r_reg;
  ecm_dev_state_t r_next;

  // Next state of the whole subsystem
  always_comb begin
    logic [AW-1:0] ridx;
    logic m;
    int k;
    int base;
    ecm_pkg::ecm_fix_t rf;
    ecm_pkg::ecm_fix_t lf;
    logic evt;
    logic take;
    logic hit;
    logic [63:0] wd;
    logic [9:0] wc;
    r_next = r_reg;
    r_next.rvalid = 1'b0;
    r_next.cfg_rdata = 32'h0000_0000;
    ridx = (r_reg.st == ECM_FILL) ? {1'b0, r_reg.ltag, r_reg.beat} : lnk.addr;
    m = ridx[AW-1];
    k = m ? DW1 : DW0;
    rf = ecm_pkg::ecm_fix(256'(r_reg.mem[ridx][63:0]), r_reg.mem[ridx][73:64], k);
    lf = ecm_pkg::ecm_fix(r_reg.line, r_reg.lchk, ecm_pkg::ECM_LINE_W);
    take = lnk.req && r_reg.rdy;
    hit = r_reg.lval && (r_reg.ltag == lnk.addr[AW-2:2]);
    evt = 1'b0;
    wd = 64'h0;
    wc = 10'h000;
    base = 0;

    // Global configuration writes and readback
    if (lnk.cfg_wr && lnk.cfg_addr == ecm_pkg::ECM_CFG_GCTRL) begin
      r_next.gie = lnk.cfg_wdata[ecm_pkg::ECM_G_IRQEN];
      r_next.cen = lnk.cfg_wdata[ecm_pkg::ECM_G_CEN];
      if (!r_reg.cen) r_next.cecc = lnk.cfg_wdata[ecm_pkg::ECM_G_CECC];
      if (!lnk.cfg_wdata[ecm_pkg::ECM_G_CEN]) r_next.lval = 1'b0; // Disable flushes
    end
    if (lnk.cfg_wr && lnk.cfg_addr == ecm_pkg::ECM_CFG_INJECT) begin
      r_next.inj = lnk.cfg_wdata[3:0];
    end
    if (lnk.cfg_rd && lnk.cfg_addr == ecm_pkg::ECM_CFG_GCTRL) begin
      r_next.cfg_rdata = {29'h0, r_reg.cecc, r_reg.cen, r_reg.gie};
    end
    if (lnk.cfg_rd && lnk.cfg_addr == ecm_pkg::ECM_CFG_INJECT) begin
      r_next.cfg_rdata = {28'h0, r_reg.inj};
    end

    // Per-monitor control, status clear and readback
    for (int i = 0; i < ecm_pkg::ECM_MONS; i++) begin
      base = ecm_pkg::ECM_CFG_MON_BASE + i * ecm_pkg::ECM_CFG_MON_STRIDE;
      if (lnk.cfg_wr && lnk.cfg_addr == 4'(base + ecm_pkg::ECM_MON_CTRL)) begin
        r_next.mctl[i] = lnk.cfg_wdata[2:0];
      end
      if (lnk.cfg_wr && lnk.cfg_addr == 4'(base + ecm_pkg::ECM_MON_STAT)) begin
        r_next.stat[i] = r_reg.stat[i] & ~lnk.cfg_wdata[1:0]; // Write one to clear
      end
      if (lnk.cfg_rd) begin
        if (lnk.cfg_addr == 4'(base + ecm_pkg::ECM_MON_CTRL)) begin
          r_next.cfg_rdata = {29'h0, r_reg.mctl[i]};
        end
        if (lnk.cfg_addr == 4'(base + ecm_pkg::ECM_MON_STAT)) begin
          r_next.cfg_rdata = {30'h0, r_reg.stat[i]};
        end
        if (lnk.cfg_addr == 4'(base + ecm_pkg::ECM_MON_FADDR)) begin
          r_next.cfg_rdata = 32'(r_reg.faddr[i]);
        end
        if (lnk.cfg_addr == 4'(base + ecm_pkg::ECM_MON_FDLO)) begin
          r_next.cfg_rdata = r_reg.fdata[i][31:0];
        end
        if (lnk.cfg_addr == 4'(base + ecm_pkg::ECM_MON_FDHI)) begin
          r_next.cfg_rdata = r_reg.fdata[i][63:32];
        end
      end
    end

    // Access sequencing
    case (r_reg.st)
      ECM_IDLE: begin
        if (take) begin
          if (!lnk.write && r_reg.cen && !m) begin
            if (hit && !(r_reg.cecc && lf.ded)) begin
              // Cache errors stay internal: no flag, no latch
              if (r_reg.cecc) begin
                r_next.rdata = lf.data[lnk.addr[1:0]*64 +: 64];
              end else begin
                r_next.rdata = r_reg.line[lnk.addr[1:0]*64 +: 64];
              end
              r_next.rvalid = 1'b1;
            end else begin
              // Miss or uncorrectable line: drop it and refill from SRAM
              r_next.lval = 1'b0;
              r_next.ltag = lnk.addr[AW-2:2];
              r_next.rword = lnk.addr[1:0];
              r_next.beat = 2'd0;
              r_next.st = ECM_FILL;
            end
          end else if (lnk.write) begin
            evt = m ? (lnk.be[3:0] != 4'hf) : (lnk.be != 8'hff);
            for (int b = 0; b < 8; b++) begin
              wd[b*8 +: 8] = lnk.be[b] ? lnk.wdata[b*8 +: 8] : rf.data[b*8 +: 8];
            end
            if (m) wd[63:32] = 32'h0;
            wc = ecm_pkg::ecm_code(256'(wd), k);
            r_next.mem[ridx] = {wc, wd ^ {62'h0, r_reg.inj[1:0]}};
            r_next.inj[1:0] = 2'b00;
            if (hit && !m) r_next.lval = 1'b0; // Writes go around the line
            r_next.rdata = 64'h0;
            r_next.rvalid = 1'b1;
          end else begin
            evt = 1'b1;
            r_next.rdata = rf.data[63:0];
            r_next.rvalid = 1'b1;
          end
        end
      end
      ECM_FILL: begin
        evt = 1'b1;
        r_next.line[r_reg.beat*64 +: 64] = rf.data[63:0];
        r_next.beat = r_reg.beat + 2'd1;
        if (r_reg.beat == 2'd3) begin
          r_next.lchk = ecm_pkg::ecm_code(r_next.line, ecm_pkg::ECM_LINE_W);
          r_next.rdata = r_next.line[r_reg.rword*64 +: 64];
          r_next.line[1:0] = r_next.line[1:0] ^ r_reg.inj[3:2];
          r_next.inj[3:2] = 2'b00;
          r_next.lval = 1'b1;
          r_next.rvalid = 1'b1;
          r_next.st = ECM_IDLE;
        end
      end
      default: begin
        r_next.st = ECM_IDLE;
      end
    endcase

    // Monitor events; applied after the clear so a new event wins
    if (evt && (rf.sec || rf.ded)) begin
      r_next.stat[m] = r_next.stat[m] | {rf.ded, rf.sec};
      if (r_reg.mctl[m][ecm_pkg::ECM_M_LATCH]) begin
        r_next.faddr[m] = ridx;
        r_next.fdata[m] = rf.data[63:0];
      end
    end

    // Global interrupt gathers every enabled monitor flag
    r_next.irq = 1'b0;
    for (int i = 0; i < ecm_pkg::ECM_MONS; i++) begin
      if ((r_next.stat[i][ecm_pkg::ECM_S_SEC] && r_next.mctl[i][ecm_pkg::ECM_M_SECIE]) ||
          (r_next.stat[i][ecm_pkg::ECM_S_DED] && r_next.mctl[i][ecm_pkg::ECM_M_DEDIE])) begin
        r_next.irq = r_next.gie;
      end
    end
    r_next.rdy = (r_next.st == ECM_IDLE) && !take;
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
      r_reg.cecc <= ecm_pkg::ECM_CECC_RST;
      r_reg.rdy <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign lnk.ready = r_reg.rdy;
  assign lnk.rvalid = r_reg.rvalid;
  assign lnk.rdata = r_reg.rdata;
  assign lnk.cfg_rdata = r_reg.cfg_rdata;
  assign ecc_irq = r_reg.irq;

endmodule // ecm_mem_dev

// file: hdl/ecm_pkg.sv
// Shared constants, types and SEC-DED code functions for the RAM/cache ECC pair.
// Assumes one system clock; both ends import nothing and use ecm_pkg:: names.
package ecm_pkg;

  // Access address width; top address bit selects the data close RAM
  localparam int ECM_AW = 5;
  localparam int ECM_LINE_W = 256;
  localparam int ECM_MONS = 2;

  // Device configuration word indexes
  localparam logic [3:0] ECM_CFG_GCTRL = 4'h0;
  localparam logic [3:0] ECM_CFG_INJECT = 4'h1;
  localparam int ECM_CFG_MON_BASE = 2;
  localparam int ECM_CFG_MON_STRIDE = 5;
  localparam int ECM_MON_CTRL = 0;
  localparam int ECM_MON_STAT = 1;
  localparam int ECM_MON_FADDR = 2;
  localparam int ECM_MON_FDLO = 3;
  localparam int ECM_MON_FDHI = 4;

  // Field positions
  localparam int ECM_G_IRQEN = 0;
  localparam int ECM_G_CEN = 1;
  localparam int ECM_G_CECC = 2;
  localparam int ECM_M_LATCH = 0;
  localparam int ECM_M_SECIE = 1;
  localparam int ECM_M_DEDIE = 2;
  localparam int ECM_S_SEC = 0;
  localparam int ECM_S_DED = 1;
  localparam logic ECM_CECC_RST = 1'b1;

  // Controller software offsets
  localparam logic [3:0] ECM_SW_ADDR = 4'h0;
  localparam logic [3:0] ECM_SW_WDLO = 4'h1;
  localparam logic [3:0] ECM_SW_WDHI = 4'h2;
  localparam logic [3:0] ECM_SW_CMD = 4'h3;
  localparam logic [3:0] ECM_SW_RDLO = 4'h4;
  localparam logic [3:0] ECM_SW_RDHI = 4'h5;
  localparam logic [3:0] ECM_SW_STATUS = 4'h6;
  localparam logic [3:0] ECM_SW_CADDR = 4'h7;
  localparam logic [3:0] ECM_SW_CDATA = 4'h8;
  localparam logic [3:0] ECM_SW_CREAD = 4'h9;
  localparam int ECM_CMD_WR = 0;
  localparam int ECM_CMD_INSTR = 1;
  localparam int ECM_CMD_BE_LSB = 8;

  typedef struct packed {
    logic [255:0] data;
    logic sec;
    logic ded;
  } ecm_fix_t;

  // Hamming bits for k data bits (overall parity comes on top)
  function automatic int ecm_rbits(input int k);
    int r;
    r = 0;
    for (int j = 0; j < 10; j++) begin
      if ((1 << r) < k + r + 1) r = r + 1;
    end
    return r;
  endfunction

  // Next codeword position that is not a power of two
  function automatic int ecm_next_pos(input int p);
    int q;
    q = p + 1;
    if ((q & (q - 1)) == 0) q = q + 1;
    if ((q & (q - 1)) == 0) q = q + 1;
    return q;
  endfunction

  // Check bits: Hamming bits low, overall parity at bit r
  function automatic logic [9:0] ecm_code(input logic [255:0] d, input int k);
    logic [9:0] c;
    int p;
    int r;
    c = '0;
    p = 2;
    r = ecm_rbits(k);
    for (int i = 0; i < 256; i++) begin
      if (i < k) begin
        p = ecm_next_pos(p);
        for (int j = 0; j < 9; j++) begin
          if (p[j] && d[i]) c[j] = ~c[j];
        end
      end
    end
    c[r] = ^{d, c};
    return c;
  endfunction

  // Decode: flip one data bit on a single error, flag a double error
  function automatic ecm_fix_t ecm_fix(input logic [255:0] d, input logic [9:0] c,
                                       input int k);
    ecm_fix_t f;
    logic [9:0] s;
    int p;
    int r;
    f.data = d;
    f.sec = 1'b0;
    f.ded = 1'b0;
    p = 2;
    r = ecm_rbits(k);
    s = ecm_code(d, k) ^ c;
    s[r] = ^{d, c};
    if (s[r]) begin
      f.sec = 1'b1;
      for (int i = 0; i < 256; i++) begin
        if (i < k) begin
          p = ecm_next_pos(p);
          if (p == int'(s) - (1 << r)) f.data[i] = ~d[i];
        end
      end
    end else if (s != 10'h000) begin
      f.ded = 1'b1;
    end
    return f;
  endfunction

endpackage
